/* File: rtl/kmsg_pkg.sv */
/*
  package for the keyboard matrix scan gpio block: register offsets, reset values,
  pin function codes and the packed carriers shared by the top and its leaves.
  assumes an apb slave with 32-bit data; each register holds its low 8 bits, the mode registers their low 24.
*/
`default_nettype none
package kmsg_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_MODE_A     = 8'h58;
  localparam logic [7:0] IDX_MODE_B     = 8'h59;
  localparam logic [7:0] IDX_MODE_C     = 8'h5A;
  localparam logic [7:0] IDX_DATA_C     = 8'h5E;
  localparam logic [7:0] IDX_SCAN_A     = 8'h60;
  localparam logic [7:0] IDX_SCAN_B     = 8'h61;
  localparam logic [7:0] IDX_SCAN_C     = 8'h62;
  localparam logic [7:0] IDX_RET_A      = 8'h63;
  localparam logic [7:0] IDX_RET_B      = 8'h64;
  localparam logic [7:0] IDX_RET_C      = 8'h65;
  localparam logic [7:0] IDX_SCAN_CFG   = 8'h66;
  localparam logic [7:0] IDX_SYS_STATUS = 8'h69;
  localparam logic [9:0] ADDR_MASK      = 10'h3FF;
  // reset values
  localparam logic [7:0] RST_SCAN_DRIVE = 8'h00;
  localparam logic [7:0] RST_RETURN     = 8'hFF;
  localparam logic [7:0] RST_SCAN_CFG   = 8'h00;
  localparam logic [7:0] RST_DATA       = 8'h00;
  localparam logic [2:0] RST_MODE       = 3'h0;
  // field positions of the scan configuration register
  localparam int CFG_SWITCH_LSB = 4;
  localparam int CFG_SWITCH_MSB = 7;
  localparam int CFG_SOURCE_BIT = 3;
  localparam int CFG_SENSE_BIT  = 2;
  localparam int CFG_RATE_MSB   = 1;
  localparam int CFG_RATE_LSB   = 0;
  // three-bit pin function codes, one per pin
  localparam logic [2:0] FN_GP_IN  = 3'h0;
  localparam logic [2:0] FN_SENSE  = 3'h3;
  localparam logic [2:0] FN_GP_OUT = 3'h4;
  localparam logic [2:0] FN_SCAN   = 3'h7;
  localparam int         PIN_COUNT = 8;
  // a timing count: synchroniser depth
  localparam int         SYNC_STAGES = 3;

  typedef struct packed {
    logic [7:0] gp_in;
    logic [7:0] gp_out;
    logic [7:0] sense;
    logic [7:0] scan;
  } kmsg_fn_t;

  typedef struct packed {
    logic [1:0] floppy_code;
    logic [1:0] display_code;
    logic       primary_kbd_source_sel;
    logic       matrix_sense_mode;
    logic [1:0] periodic_nmi_rate_sel;
  } kmsg_cfg_t;
endpackage
`default_nettype wire

/* File: rtl/kmsg_sync.sv */
/*
  three-flop input synchroniser for one pin group; a change is taken once the
  second and third flops agree. assumes pins are asynchronous to pclk.
*/
`default_nettype none
module kmsg_sync (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // pins and result
  input  wire logic [7:0] pin_in,
  output var  logic [7:0] level
);
  logic [7:0] stage1;
  logic [7:0] stage2;
  logic [7:0] stage3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= kmsg_pkg::RST_RETURN;
      stage2 <= kmsg_pkg::RST_RETURN;
      stage3 <= kmsg_pkg::RST_RETURN;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // per bit, keep the old level until the later two flops agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= kmsg_pkg::RST_RETURN;
    end else begin
      level <= (stage2 & stage3) | (level & (stage2 ^ stage3));
    end
  end
endmodule
`default_nettype wire

/* File: rtl/kmsg_mode_decode.sv */
/*
  decodes a group mode word (three bits per pin) into per-pin function masks.
  assumes the mode word comes from registers on the same clock.
*/
`default_nettype none
module kmsg_mode_decode (
  // mode word
  input  wire logic [23:0]             mode,
  // decoded functions
  output var  kmsg_pkg::kmsg_fn_t      fn
);
  always_comb begin
    fn = '0;
    for (int i = 0; i < kmsg_pkg::PIN_COUNT; i++) begin
      fn.gp_in[i]  = (mode[3*i +: 3] == kmsg_pkg::FN_GP_IN);
      fn.gp_out[i] = (mode[3*i +: 3] == kmsg_pkg::FN_GP_OUT);
      fn.sense[i]  = (mode[3*i +: 3] == kmsg_pkg::FN_SENSE);
      fn.scan[i]   = (mode[3*i +: 3] == kmsg_pkg::FN_SCAN);
    end
  end
endmodule
`default_nettype wire

/* File: rtl/kmsg_top.sv */
/*
  keyboard matrix scan gpio block: apb register slave, group c data register,
  scan drive registers for groups a/b/c, return status registers and the
  keyboard scan configuration register.
  assumes a single pclk domain; pins arrive asynchronously and are synchronised.
  pin drive: oe_n low means the pin is driven, by *_out.
*/
// Notes on behaviour
// - group c outputs drive written data bits
// - group c output bits read back written value
// - group c input bits read pin, ignore writes
// - other data bits ignore writes, read zero
// - group b scan pins follow second drive register
// - group c scan pins follow third drive register
// - first return register shows group a pins
// - unassigned first return bits read one
// - second return register shows group b sense pins
// - third return register shows group c sense pins
// - switch nibble resets zero, readable via status port
// - switch codes mean floppy count and display
// - switch bits control no hardware
// - bit 3 selects primary keyboard source
// - bit 2 selects full or partial scan
// - bits 1:0 select periodic nmi rate
`default_nettype none
module kmsg_top (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // group a pins
  input  wire logic [7:0]  group_a_in,
  output logic [7:0]       group_a_out,
  output logic [7:0]       group_a_oe_n,
  // group b pins
  input  wire logic [7:0]  group_b_in,
  output logic [7:0]       group_b_out,
  output logic [7:0]       group_b_oe_n,
  // group c pins
  input  wire logic [7:0]  group_c_in,
  output logic [7:0]       group_c_out,
  output logic [7:0]       group_c_oe_n,
  // configuration to the keyboard and nmi logic
  output logic             primary_kbd_source_sel,
  output logic             matrix_sense_mode,
  output logic [1:0]       periodic_nmi_rate_sel
);
  logic [23:0]         mode_a;
  logic [23:0]         mode_b;
  logic [23:0]         mode_c;
  logic [7:0]          group_c_data_bits;
  logic [7:0]          scan_drive_group_a;
  logic [7:0]          scan_drive_group_b;
  logic [7:0]          scan_drive_group_c;
  kmsg_pkg::kmsg_cfg_t keyboard_scan_config;
  kmsg_pkg::kmsg_fn_t  fn_a;
  kmsg_pkg::kmsg_fn_t  fn_b;
  kmsg_pkg::kmsg_fn_t  fn_c;
  logic [7:0]          level_a;
  logic [7:0]          level_b;
  logic [7:0]          level_c;
  logic [7:0]          return_status_group_a;
  logic [7:0]          return_status_group_b;
  logic [7:0]          return_status_group_c;
  logic [7:0]          legacy_system_status_port;
  logic [7:0]          data_c_view;
  logic [7:0]          next_rdata;
  logic                next_err;
  logic [9:0]          index;
  logic                setup;
  logic                wr;
  logic [7:0]          wbyte;
  logic [7:0]          next_out_a;
  logic [7:0]          next_oe_a;
  logic [7:0]          next_out_b;
  logic [7:0]          next_oe_b;
  logic [7:0]          next_out_c;
  logic [7:0]          next_oe_c;

  assign index = paddr[11:2] & kmsg_pkg::ADDR_MASK;
  assign setup = psel && !penable;
  // answer in the cycle after setup, so one wait-free access phase
  assign wr    = psel && penable && pready && pwrite;
  assign wbyte = pwdata[7:0];

  // one decoder per group; the decode is pure logic on registered mode words
  kmsg_mode_decode u_dec_a (
    .mode (mode_a),
    .fn   (fn_a)
  );
  kmsg_mode_decode u_dec_b (
    .mode (mode_b),
    .fn   (fn_b)
  );
  kmsg_mode_decode u_dec_c (
    .mode (mode_c),
    .fn   (fn_c)
  );

  // pins reach the return and data views only through these; a key change
  // shows up in a read four to five edges later, which software never notices
  kmsg_sync u_sync_a (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (group_a_in),
    .level   (level_a)
  );
  kmsg_sync u_sync_b (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (group_b_in),
    .level   (level_b)
  );
  kmsg_sync u_sync_c (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (group_c_in),
    .level   (level_c)
  );

  // mode registers, three bits per pin packed low pin first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_a <= {8{kmsg_pkg::RST_MODE}};
    end else if (wr && index == {2'h0, kmsg_pkg::IDX_MODE_A}) begin
      mode_a <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_b <= {8{kmsg_pkg::RST_MODE}};
    end else if (wr && index == {2'h0, kmsg_pkg::IDX_MODE_B}) begin
      mode_b <= pwdata[23:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_c <= {8{kmsg_pkg::RST_MODE}};
    end else if (wr && index == {2'h0, kmsg_pkg::IDX_MODE_C}) begin
      mode_c <= pwdata[23:0];
    end
  end

  // only output-mode bits take a write; others keep their value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_c_data_bits <= kmsg_pkg::RST_DATA;
    end else if (wr && index == {2'h0, kmsg_pkg::IDX_DATA_C}) begin
      group_c_data_bits <= (wbyte & fn_c.gp_out) | (group_c_data_bits & ~fn_c.gp_out);
    end
  end

  // drive registers keep all eight bits; only scan-mode pins act on them,
  // so software may preload a drive pattern before switching the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_drive_group_a <= kmsg_pkg::RST_SCAN_DRIVE;
    end else if (wr && index == {2'h0, kmsg_pkg::IDX_SCAN_A}) begin
      scan_drive_group_a <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_drive_group_b <= kmsg_pkg::RST_SCAN_DRIVE;
    end else if (wr && index == {2'h0, kmsg_pkg::IDX_SCAN_B}) begin
      scan_drive_group_b <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_drive_group_c <= kmsg_pkg::RST_SCAN_DRIVE;
    end else if (wr && index == {2'h0, kmsg_pkg::IDX_SCAN_C}) begin
      scan_drive_group_c <= wbyte;
    end
  end

  // the switch nibble is stored only; no logic reads it but the status port and the config register readback
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keyboard_scan_config <= kmsg_pkg::RST_SCAN_CFG;
    end else if (wr && index == {2'h0, kmsg_pkg::IDX_SCAN_CFG}) begin
      keyboard_scan_config.floppy_code  <= wbyte[kmsg_pkg::CFG_SWITCH_MSB -: 2];
      keyboard_scan_config.display_code <= wbyte[kmsg_pkg::CFG_SWITCH_LSB +: 2];
      keyboard_scan_config.primary_kbd_source_sel <= wbyte[kmsg_pkg::CFG_SOURCE_BIT];
      keyboard_scan_config.matrix_sense_mode      <= wbyte[kmsg_pkg::CFG_SENSE_BIT];
      keyboard_scan_config.periodic_nmi_rate_sel  <=
        wbyte[kmsg_pkg::CFG_RATE_MSB:kmsg_pkg::CFG_RATE_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_kbd_source_sel <= 1'b0;
      matrix_sense_mode      <= 1'b0;
      periodic_nmi_rate_sel  <= 2'h0;
    end else begin
      primary_kbd_source_sel <= keyboard_scan_config.primary_kbd_source_sel;
      matrix_sense_mode      <= keyboard_scan_config.matrix_sense_mode;
      periodic_nmi_rate_sel  <= keyboard_scan_config.periodic_nmi_rate_sel;
    end
  end

  // return registers are pure views: no storage, so writes cannot alter them
  assign return_status_group_a = level_a | ~fn_a.sense;
  assign return_status_group_b = level_b | ~fn_b.sense;
  assign return_status_group_c = level_c | ~fn_c.sense;
  assign legacy_system_status_port = {keyboard_scan_config.floppy_code,
                                      keyboard_scan_config.display_code, 4'h0};
  assign data_c_view = (group_c_data_bits & fn_c.gp_out) | (level_c & fn_c.gp_in);

  always_comb begin
    next_rdata = 8'h00;
    next_err   = 1'b0;
    unique case (index)
      {2'h0, kmsg_pkg::IDX_DATA_C}:     next_rdata = data_c_view;
      {2'h0, kmsg_pkg::IDX_SCAN_A}:     next_rdata = scan_drive_group_a;
      {2'h0, kmsg_pkg::IDX_SCAN_B}:     next_rdata = scan_drive_group_b;
      {2'h0, kmsg_pkg::IDX_SCAN_C}:     next_rdata = scan_drive_group_c;
      {2'h0, kmsg_pkg::IDX_RET_A}:      next_rdata = return_status_group_a;
      {2'h0, kmsg_pkg::IDX_RET_B}:      next_rdata = return_status_group_b;
      {2'h0, kmsg_pkg::IDX_RET_C}:      next_rdata = return_status_group_c;
      {2'h0, kmsg_pkg::IDX_SCAN_CFG}:   next_rdata = keyboard_scan_config;
      {2'h0, kmsg_pkg::IDX_SYS_STATUS}: next_rdata = legacy_system_status_port;
      {2'h0, kmsg_pkg::IDX_MODE_A},
      {2'h0, kmsg_pkg::IDX_MODE_B},
      {2'h0, kmsg_pkg::IDX_MODE_C}:     next_rdata = 8'h00;
      default:                          next_err   = 1'b1;
    endcase
  end

  // apb: pready pulses one cycle after setup; read data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && next_err;
      if (setup) begin
        unique case (index)
          {2'h0, kmsg_pkg::IDX_MODE_A}: prdata <= {8'h00, mode_a};
          {2'h0, kmsg_pkg::IDX_MODE_B}: prdata <= {8'h00, mode_b};
          {2'h0, kmsg_pkg::IDX_MODE_C}: prdata <= {8'h00, mode_c};
          default:                      prdata <= {24'h00_0000, next_rdata};
        endcase
      end
    end
  end

  // scan lines are open drain: 1 drives low, 0 floats; group c gp outputs drive data
  always_comb begin
    next_out_a = 8'h00;
    next_oe_a  = ~(fn_a.scan & scan_drive_group_a);
    next_out_b = 8'h00;
    next_oe_b  = ~(fn_b.scan & scan_drive_group_b);
    next_out_c = group_c_data_bits & fn_c.gp_out;
    next_oe_c  = ~((fn_c.scan & scan_drive_group_c) | fn_c.gp_out);
  end

  // pin drive is registered so the pads never see decode glitches; the cost
  // is one edge between a committed write and the pin change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_a_out  <= 8'h00;
      group_a_oe_n <= 8'hFF;
    end else begin
      group_a_out  <= next_out_a;
      group_a_oe_n <= next_oe_a;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_b_out  <= 8'h00;
      group_b_oe_n <= 8'hFF;
    end else begin
      group_b_out  <= next_out_b;
      group_b_oe_n <= next_oe_b;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_c_out  <= 8'h00;
      group_c_oe_n <= 8'hFF;
    end else begin
      group_c_out  <= next_out_c;
      group_c_oe_n <= next_oe_c;
    end
  end
endmodule
`default_nettype wire

/* File: tb/kmsg_asserts.sv */
/*
  checker for kmsg_top: apb handshake, refusal, config outputs, pin stability.
  assumes it is bound to kmsg_top and sees only its ports.
*/
`default_nettype none
module kmsg_asserts (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // pins
  input wire logic [7:0]  group_a_oe_n,
  input wire logic [7:0]  group_b_oe_n,
  input wire logic [7:0]  group_c_oe_n,
  input wire logic [7:0]  group_c_out,
  // configuration
  input wire logic        primary_kbd_source_sel,
  input wire logic        matrix_sense_mode,
  input wire logic [1:0]  periodic_nmi_rate_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_any;
  logic wr_cfg;
  assign wr_any = psel && penable && pready && pwrite;
  assign wr_cfg = wr_any && paddr == 12'h198;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_cfgw; s_setup ##1 wr_cfg; endsequence
  property p_ready_next; s_setup |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready longer than a cycle");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_unmapped; s_setup ##0 paddr == 12'h1C0 |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read data not zero");
  property p_rd_hold; !(psel && !penable) |=> $stable(prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without setup");
  property p_cfg_out;
    s_cfgw |-> ##2 {primary_kbd_source_sel, matrix_sense_mode, periodic_nmi_rate_sel}
      == $past(pwdata[3:0], 2);
  endproperty
  a_cfg_out: assert property (p_cfg_out) else $error("config outputs differ");
  property p_cfg_hold;
    !wr_cfg ##1 !wr_cfg |=> $stable({primary_kbd_source_sel, matrix_sense_mode,
      periodic_nmi_rate_sel});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved without write");
  property p_pin_hold;
    !wr_any ##1 !wr_any |=> $stable({group_a_oe_n, group_b_oe_n, group_c_oe_n, group_c_out});
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin drive moved alone");
endmodule
`default_nettype wire

/* File: tb/kmsg_matrix.sv */
/*
  keyboard matrix partner: an undriven pin floats high on its pull-up and a
  held key pulls it low. assumes oe_n low means the block drives the pin.
*/
`default_nettype none
module kmsg_matrix (
  // pin drive from the block
  input  wire logic [7:0] drv  [3],
  input  wire logic [7:0] oe_n [3],
  // keys held by the bench
  input  wire logic [7:0] key  [3],
  // resolved pin levels
  output var  logic [7:0] lvl  [3]
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    for (int g = 0; g < 3; g++) begin
      lvl[g] = (drv[g] & ~oe_n[g]) | (~key[g] & oe_n[g]);
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
  self-checking bench for kmsg_top with an apb master and a matrix partner.
  assumes the checker and partner files are compiled before this one.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        prim, smode;
  logic [1:0]  rate;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pin_in [3], pin_out [3], pin_oe_n [3], key [3];
  logic [7:0]  v, o, i, d;
  logic [23:0] m;
  int          err_count, cmp_count, cyc;

  kmsg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .group_a_in(pin_in[0]), .group_a_out(pin_out[0]),
    .group_a_oe_n(pin_oe_n[0]), .group_b_in(pin_in[1]), .group_b_out(pin_out[1]),
    .group_b_oe_n(pin_oe_n[1]), .group_c_in(pin_in[2]), .group_c_out(pin_out[2]),
    .group_c_oe_n(pin_oe_n[2]), .primary_kbd_source_sel(prim), .matrix_sense_mode(smode),
    .periodic_nmi_rate_sel(rate));
  kmsg_matrix mx_u (.drv(pin_out), .oe_n(pin_oe_n), .key(key), .lvl(pin_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer; ends one idle edge later so the next setup never collides
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [23:0] mk(input logic [7:0] m1, input logic [2:0] c1,
                                     input logic [7:0] m2, input logic [2:0] c2,
                                     input logic [2:0] c0);
    logic [23:0] r;
    for (int k = 0; k < 8; k++) r[3*k+:3] = m1[k] ? c1 : (m2[k] ? c2 : c0);
    return r;
  endfunction

  // an undriven pin sits high unless its key pulls it down; unused bits read one
  function automatic logic [7:0] exp_ret(input logic [7:0] k, input logic [7:0] sense);
    return ~(k & sense);
  endfunction

  // output bits give the stored value, input bits the pin, all others zero
  function automatic logic [7:0] exp_data_c(input logic [7:0] dat, input logic [7:0] outs,
                                            input logic [7:0] ins, input logic [7:0] k);
    return (dat & outs) | (~k & ins);
  endfunction

  initial begin
    void'($urandom(53792));
    {psel, penable, pwrite, paddr, pwdata} = '0;
    key = '{default: 8'h00};
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int g = 0; g < 3; g++) begin
      check(32'(pin_oe_n[g]), 32'hFF);
      apb(1'b0, kmsg_pkg::IDX_RET_A + 8'(g), 32'h0);
      check(rd, 32'hFF);
    end
    apb(1'b0, kmsg_pkg::IDX_SYS_STATUS, 32'h0);
    check(rd, 32'h0);
    for (int n = 0; n < 8; n++) begin
      v = 8'($urandom);
      v[1:0] = 2'(n);
      apb(1'b1, kmsg_pkg::IDX_SCAN_CFG, {24'h0, v});
      apb(1'b0, kmsg_pkg::IDX_SCAN_CFG, 32'h0);
      check(rd, {24'h0, v});
      check(32'({prim, smode, rate}), 32'(v[3:0]));
      apb(1'b0, kmsg_pkg::IDX_SYS_STATUS, 32'h0);
      check(rd, {24'h0, v[7:4], 4'h0});
      check(32'(pin_oe_n[0]), 32'hFF);
    end
    for (int g = 0; g < 3; g++) begin
      o = 8'($urandom);
      key[g] <= 8'($urandom);
      apb(1'b1, kmsg_pkg::IDX_MODE_A + 8'(g),
          {8'h0, mk(o, kmsg_pkg::FN_SENSE, 8'h0, 3'h0, kmsg_pkg::FN_GP_IN)});
      repeat (6) @(posedge pclk);
      apb(1'b0, kmsg_pkg::IDX_RET_A + 8'(g), 32'h0);
      check(rd, {24'h0, exp_ret(key[g], o)});
      apb(1'b1, kmsg_pkg::IDX_RET_A + 8'(g), 32'h0);
      apb(1'b0, kmsg_pkg::IDX_RET_A + 8'(g), 32'h0);
      check(rd, {24'h0, exp_ret(key[g], o)});
      v = 8'($urandom);
      apb(1'b1, kmsg_pkg::IDX_MODE_A + 8'(g),
          {8'h0, mk(8'hFF, kmsg_pkg::FN_SCAN, 8'h0, 3'h0, 3'h0)});
      apb(1'b1, kmsg_pkg::IDX_SCAN_A + 8'(g), {24'h0, v});
      apb(1'b0, kmsg_pkg::IDX_SCAN_A + 8'(g), 32'h0);
      check(rd, {24'h0, v});
      check(32'(er), 32'h0);
      repeat (2) @(posedge pclk);
      check(32'(pin_oe_n[g]), {24'h0, ~v});
      check(32'(pin_out[g] & v), 32'h0);
    end
    for (int n = 0; n < 6; n++) begin
      o = 8'($urandom);
      i = 8'($urandom) & ~o;
      d = 8'($urandom);
      m = mk(o, kmsg_pkg::FN_GP_OUT, i, kmsg_pkg::FN_GP_IN, kmsg_pkg::FN_SENSE);
      apb(1'b1, kmsg_pkg::IDX_MODE_C, {8'h0, m});
      apb(1'b0, kmsg_pkg::IDX_MODE_C, 32'h0);
      check(rd, {8'h0, m});
      apb(1'b1, kmsg_pkg::IDX_DATA_C, {24'h0, d});
      repeat (6) @(posedge pclk);
      check(32'(pin_out[2] & o), 32'(d & o));
      check(32'(pin_oe_n[2] & o), 32'h0);
      apb(1'b0, kmsg_pkg::IDX_DATA_C, 32'h0);
      check(rd, {24'h0, exp_data_c(d, o, i, key[2])});
    end
    apb(1'b1, 8'h70, 32'hFF);
    check(32'(er), 32'h1);
    apb(1'b0, 8'h70, 32'h0);
    check(32'(er), 32'h1);
    check(rd, 32'h0);
    test_done();
  end
endmodule

bind kmsg_top kmsg_asserts chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .prdata, .group_a_oe_n, .group_b_oe_n, .group_c_oe_n,
  .group_c_out, .primary_kbd_source_sel, .matrix_sense_mode, .periodic_nmi_rate_sel);
`default_nettype wire
